// File: logic/timer0_consts.svh
// Named offsets, field positions and values for the timer0 waveform block
`ifndef TIMER0_CONSTS_SVH
`define TIMER0_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_COUNTER 8'h08
`define OFS_CMP_A 8'h0c
`define OFS_CMP_B 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_MASK 8'h18
`define OFS_PIN_CTRL 8'h1c
// Register indices, one per word
`define IDX_CTRL_A 4'h0
`define IDX_CTRL_B 4'h1
`define IDX_COUNTER 4'h2
`define IDX_CMP_A 4'h3
`define IDX_CMP_B 4'h4
`define IDX_INT_STATUS 4'h5
`define IDX_INT_MASK 4'h6
`define IDX_PIN_CTRL 4'h7
`define IDX_NONE 4'hf
// Field positions of control_a
`define COMA_HI 7
`define COMA_LO 6
`define COMB_HI 5
`define COMB_LO 4
`define WGM_HI 1
`define WGM_LO 0
// Field positions of control_b
`define MODE_HI_BIT 3
`define RUN_BIT 0
// Field positions of pin control
`define DIR_A_BIT 0
`define DIR_B_BIT 1
`define PORT_A_BIT 4
`define PORT_B_BIT 5
// Interrupt status bits
`define ST_OVF 0
`define ST_MATCH_A 1
`define ST_MATCH_B 2
// Values
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00
`define CNT_STEP 8'h01
`define COM_OFF 2'b00
`define COM_TOGGLE 2'b01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define REG_RESET 8'h00
`define ST_RESET 3'h0
`define MODE_PHASE_FF 3'h1
`define MODE_CLEAR_ON_MATCH 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PHASE_CMP 3'h5
`define MODE_FAST_CMP 3'h7
`endif

// File: logic/timer0_pkg.sv
// Types shared by the timer0 waveform block
package timer0_pkg;
  // Waveform family chosen by the mode field
  typedef enum logic [1:0] {
    kind_normal = 2'b00,
    kind_phase = 2'b01,
    kind_fast = 2'b10
  } wave_kind_e;
  // Write channel progress
  typedef enum logic {
    wr_idle = 1'b0,
    wr_resp = 1'b1
  } wr_state_e;
  // Read channel progress
  typedef enum logic {
    rd_idle = 1'b0,
    rd_data = 1'b1
  } rd_state_e;
  typedef logic [7:0] byte_t;
endpackage

// File: logic/timer0_mode_decode.sv
// Decode of the 3-bit waveform generation mode
`timescale 1ns/100ps
`include "timer0_consts.svh"
module timer0_mode_decode (
  input wire logic [2:0] mode,
  output timer0_pkg::wave_kind_e kind,
  output logic top_from_compare,
  output logic ovf_at_top
);
  import timer0_pkg::*;

  // ----------------------------------------
  // Mode table
  // ----------------------------------------
  // Reserved codes fall back to normal counting with a full-range top
  always_comb begin
    kind = kind_normal;
    top_from_compare = 1'b0;
    ovf_at_top = 1'b0;
    case (mode)
      `MODE_PHASE_FF: kind = kind_phase;
      `MODE_CLEAR_ON_MATCH: top_from_compare = 1'b1;
      `MODE_FAST_FF: kind = kind_fast;
      `MODE_PHASE_CMP: begin
        kind = kind_phase;
        top_from_compare = 1'b1;
      end
      `MODE_FAST_CMP: begin
        kind = kind_fast;
        top_from_compare = 1'b1;
        ovf_at_top = 1'b1;
      end
      default: kind = kind_normal;
    endcase
  end
endmodule

// File: logic/timer0_compare_channel.sv
// One compare-output channel: the waveform flip-flop and its actions
`timescale 1ns/100ps
`include "timer0_consts.svh"
module timer0_compare_channel (
  input wire logic clock,
  input wire logic rst,
  input timer0_pkg::wave_kind_e kind,
  input wire logic [1:0] output_mode,
  input wire logic match,
  input wire logic cmp_is_top,
  input wire logic wrap,
  input wire logic at_top,
  input wire logic count_up,
  output logic wave_q
);
  import timer0_pkg::*;
  // All checks below share this clock and reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Waveform register
  // ----------------------------------------
  // Reserved code 01 in the PWM families leaves the waveform alone
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wave_q <= 1'b0;
    end else begin
      case (kind)
        kind_fast: begin
          if (output_mode[1]) begin
            // (R5) Match at top ignored
            if (match && !cmp_is_top) begin
              // (R4) Action on match
              wave_q <= output_mode[0];
            end else if (wrap) begin
              // (R4) Opposite action at bottom
              wave_q <= !output_mode[0];
            end
          end
        end
        kind_phase: begin
          if (output_mode[1]) begin
            if (cmp_is_top) begin
              // (R7) Action at top instead
              if (at_top) begin
                wave_q <= !output_mode[0];
              end
            end else if (match) begin
              // (R6) Direction picks the action
              wave_q <= count_up ? output_mode[0] : !output_mode[0];
            end
          end
        end
        default: begin
          // (R3) Non-PWM match actions
          if (match) begin
            if (output_mode == `COM_TOGGLE) begin
              wave_q <= !wave_q;
            end else if (output_mode[1]) begin
              wave_q <= output_mode[0];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  toggle_on_match_a: assert property ( // R3
    (kind == kind_normal && output_mode == `COM_TOGGLE && match) |=> wave_q != $past(wave_q))
    else $error("non-PWM toggle missed");
  fast_match_action_a: assert property ( // R4
    (kind == kind_fast && output_mode[1] && match && !cmp_is_top)
      |=> wave_q == $past(output_mode[0]))
    else $error("fast PWM match action wrong");
  fast_top_bottom_a: assert property ( // R5
    (kind == kind_fast && output_mode[1] && cmp_is_top && wrap)
      |=> wave_q == !$past(output_mode[0]))
    else $error("fast PWM bottom action wrong with compare at top");
  phase_match_dir_a: assert property ( // R6
    (kind == kind_phase && output_mode[1] && !cmp_is_top && match)
      |=> wave_q == ($past(count_up) ? $past(output_mode[0]) : !$past(output_mode[0])))
    else $error("phase PWM match action wrong");
  phase_top_hold_a: assert property ( // R7
    (kind == kind_phase && output_mode[1] && cmp_is_top && !at_top) |=> $stable(wave_q))
    else $error("phase PWM match at top not ignored");
endmodule

// File: logic/timer0_waveform_mode_control.sv
// Timer0 mode decode, counter and compare-output pin control, AXI4-Lite slave
//
// Notes on behaviour
// (R1) Nonzero output mode routes waveform to pin
// (R2) Pin driven only when direction bit set
// (R3) Non-PWM: off, toggle, clear, set on match
// (R4) Fast PWM: match action, opposite at bottom
// (R5) Fast PWM: compare at top ignores match
// (R6) Phase PWM: up and down matches act oppositely
// (R7) Phase PWM: compare at top acts at top
// (R8) Control A bits 3:2 read zero
// (R9) Mode joins control B bit with A bits
// (R10) Normal and clear-on-match: immediate update, overflow at MAX
// (R11) Phase PWM: load at top, overflow at bottom
// (R12) Fast PWM: load at bottom, overflow MAX or top
// (R13) Software avoids reserved modes 4 and 6
`timescale 1ns/100ps
`include "timer0_consts.svh"
module timer0_waveform_mode_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic irq
);
  import timer0_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by the write and read paths
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    if (addr == `OFS_CTRL_A) reg_index = `IDX_CTRL_A;
    else if (addr == `OFS_CTRL_B) reg_index = `IDX_CTRL_B;
    else if (addr == `OFS_COUNTER) reg_index = `IDX_COUNTER;
    else if (addr == `OFS_CMP_A) reg_index = `IDX_CMP_A;
    else if (addr == `OFS_CMP_B) reg_index = `IDX_CMP_B;
    else if (addr == `OFS_INT_STATUS) reg_index = `IDX_INT_STATUS;
    else if (addr == `OFS_INT_MASK) reg_index = `IDX_INT_MASK;
    else if (addr == `OFS_PIN_CTRL) reg_index = `IDX_PIN_CTRL;
    else reg_index = `IDX_NONE;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wr_state_e wr_state_q; // Write channel state
  rd_state_e rd_state_q; // Read channel state
  logic aw_got_q; // Write address held
  logic w_got_q; // Write data held
  logic [7:0] awaddr_q; // Held write address
  byte_t wdata_q; // Held low write byte
  logic wstrb_q; // Held low lane strobe
  logic [3:0] rd_idx_q; // Index of the last read
  logic [31:0] rd_value; // Read mux output
  logic wr_fire; // Write performed this cycle
  logic [3:0] wr_idx; // Index of the held write
  logic [1:0] com_a_q; // Channel A output mode
  logic [1:0] com_b_q; // Channel B output mode
  logic [1:0] wgm_low_q; // Mode bits 1:0
  logic mode_hi_q; // Mode bit 2
  logic run_q; // Counter enable
  byte_t counter_q; // Timer count
  logic count_up_q; // Dual-slope direction
  byte_t cmp_buf_q [2]; // Software-side compare values
  byte_t cmp_q [2]; // Compare values in use
  logic [2:0] int_status_q; // Sticky event bits
  logic [2:0] int_mask_q; // Event enables
  byte_t pin_ctrl_q; // Direction and port bits
  logic [2:0] mode; // Joined mode field
  wave_kind_e kind; // Waveform family
  logic top_from_compare; // Top from compare A
  logic ovf_at_top; // Overflow flag at top
  byte_t top; // Current top
  logic at_top; // Count equals top
  logic wrap; // Single-slope top to bottom
  logic at_bottom_down; // Dual-slope bottom reached
  logic ovf_event; // Overflow this cycle
  logic load_buf; // Buffered compares load now
  logic cnt_wr; // Software writes the count
  logic [1:0] com [2]; // Output modes per channel
  logic [1:0] match; // Compare matches
  logic [1:0] cmp_is_top; // Compare equals top
  logic [1:0] wave; // Waveform flip-flops
  logic [1:0] dir; // Direction bits
  logic [1:0] port; // Ordinary port values
  logic [1:0] pin_out_q; // Pin levels
  logic [1:0] pin_oe_q; // Pin enables

  // ----------------------------------------
  // AXI write channel
  // ----------------------------------------
  assign wr_fire = (wr_state_q == wr_idle) && aw_got_q && w_got_q;
  assign wr_idx = reg_index(awaddr_q);

  // Address and data are taken in either order, then one response
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_state_q <= wr_idle;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= `REG_RESET;
      wdata_q <= `REG_RESET;
      wstrb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_state_q == wr_idle && !aw_got_q) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (wr_state_q == wr_idle && !w_got_q) begin
        s_axi_wready <= 1'b1;
      end
      case (wr_state_q)
        wr_idle: begin
          if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Unmapped words answer with a slave error
            s_axi_bresp <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            wr_state_q <= wr_resp;
          end
        end
        default: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_q <= wr_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  // Read mux; narrow registers sit in the low byte
  always_comb begin
    rd_value = 32'h0;
    case (reg_index(s_axi_araddr))
      // (R8) Reserved bits 3:2 read zero
      `IDX_CTRL_A: rd_value[7:0] = {com_a_q, com_b_q, 2'b00, wgm_low_q};
      `IDX_CTRL_B: rd_value[`MODE_HI_BIT] = mode_hi_q;
      `IDX_COUNTER: rd_value[7:0] = counter_q;
      `IDX_CMP_A: rd_value[7:0] = cmp_buf_q[0];
      `IDX_CMP_B: rd_value[7:0] = cmp_buf_q[1];
      `IDX_INT_STATUS: rd_value[2:0] = int_status_q;
      `IDX_INT_MASK: rd_value[2:0] = int_mask_q;
      `IDX_PIN_CTRL: rd_value[7:0] = pin_ctrl_q;
      default: rd_value = 32'h0;
    endcase
    rd_value[`RUN_BIT] = rd_value[`RUN_BIT] | (reg_index(s_axi_araddr) == `IDX_CTRL_B && run_q);
  end

  // Data is captured at the address handshake, so reads carry no side effects
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_state_q <= rd_idle;
      rd_idx_q <= `IDX_NONE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state_q)
        rd_idle: begin
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            rd_idx_q <= reg_index(s_axi_araddr);
            s_axi_rresp <= (reg_index(s_axi_araddr) == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            rd_state_q <= rd_data;
          end else begin
            s_axi_arready <= 1'b1;
          end
        end
        default: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_q <= rd_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Reserved bits of control A and B are not stored; pin control keeps all eight bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      com_a_q <= `COM_OFF;
      com_b_q <= `COM_OFF;
      wgm_low_q <= 2'b00;
      mode_hi_q <= 1'b0;
      run_q <= 1'b0;
      int_mask_q <= `ST_RESET;
      pin_ctrl_q <= `REG_RESET;
    end else if (wr_fire && wstrb_q) begin
      if (wr_idx == `IDX_CTRL_A) begin
        com_a_q <= wdata_q[`COMA_HI:`COMA_LO];
        com_b_q <= wdata_q[`COMB_HI:`COMB_LO];
        wgm_low_q <= wdata_q[`WGM_HI:`WGM_LO];
      end else if (wr_idx == `IDX_CTRL_B) begin
        mode_hi_q <= wdata_q[`MODE_HI_BIT];
        run_q <= wdata_q[`RUN_BIT];
      end else if (wr_idx == `IDX_INT_MASK) begin
        int_mask_q <= wdata_q[2:0];
      end else if (wr_idx == `IDX_PIN_CTRL) begin
        pin_ctrl_q <= wdata_q;
      end
    end
  end

  // ----------------------------------------
  // Mode decode and counter
  // ----------------------------------------
  // (R9) Join the high bit with bits 1:0
  assign mode = {mode_hi_q, wgm_low_q};

  timer0_mode_decode u_decode (
    .mode(mode),
    .kind(kind),
    .top_from_compare(top_from_compare),
    .ovf_at_top(ovf_at_top)
  );

  assign top = top_from_compare ? cmp_q[0] : `CNT_MAX;
  assign at_top = run_q && (counter_q == top);
  assign wrap = at_top && (kind != kind_phase);
  assign at_bottom_down = run_q && (kind == kind_phase) && !count_up_q
    && (counter_q == `CNT_BOTTOM);
  assign cnt_wr = wr_fire && wstrb_q && (wr_idx == `IDX_COUNTER);

  // Single slope wraps at top; dual slope turns at top and bottom
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      counter_q <= `CNT_BOTTOM;
      count_up_q <= 1'b1;
    end else if (cnt_wr) begin
      counter_q <= wdata_q;
    end else if (run_q) begin
      if (kind == kind_phase) begin
        if (count_up_q && counter_q == top) begin
          counter_q <= counter_q - `CNT_STEP;
          count_up_q <= 1'b0;
        end else if (!count_up_q && counter_q == `CNT_BOTTOM) begin
          counter_q <= counter_q + `CNT_STEP;
          count_up_q <= 1'b1;
        end else begin
          counter_q <= count_up_q ? counter_q + `CNT_STEP : counter_q - `CNT_STEP;
        end
      end else begin
        counter_q <= wrap ? `CNT_BOTTOM : counter_q + `CNT_STEP;
        count_up_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Overflow and compare buffering
  // ----------------------------------------
  always_comb begin
    if (kind == kind_phase) begin
      // (R11) Overflow at bottom, load at top
      ovf_event = at_bottom_down;
      load_buf = at_top && count_up_q;
    end else if (kind == kind_fast) begin
      // (R12) Overflow at MAX or top, load at bottom
      ovf_event = ovf_at_top ? at_top : (run_q && counter_q == `CNT_MAX);
      load_buf = wrap;
    end else begin
      // (R10) Overflow at MAX, no buffering
      ovf_event = run_q && (counter_q == `CNT_MAX);
      load_buf = 1'b0;
    end
  end

  // ----------------------------------------
  // Per-channel compare and pin logic
  // ----------------------------------------
  assign com[0] = com_a_q;
  assign com[1] = com_b_q;
  assign dir = {pin_ctrl_q[`DIR_B_BIT], pin_ctrl_q[`DIR_A_BIT]};
  assign port = {pin_ctrl_q[`PORT_B_BIT], pin_ctrl_q[`PORT_A_BIT]};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign match[ch] = run_q && (counter_q == cmp_q[ch]);
    assign cmp_is_top[ch] = (cmp_q[ch] == top);

    // Compare values: direct in non-PWM modes, staged in PWM modes
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cmp_buf_q[ch] <= `REG_RESET;
        cmp_q[ch] <= `REG_RESET;
      end else begin
        if (wr_fire && wstrb_q && wr_idx == (`IDX_CMP_A + 4'(ch))) begin
          cmp_buf_q[ch] <= wdata_q;
          if (kind == kind_normal) begin
            cmp_q[ch] <= wdata_q;
          end
        end
        if (load_buf) begin
          cmp_q[ch] <= cmp_buf_q[ch];
        end else if (kind == kind_normal) begin
          // Leaving a PWM mode must not strand a stale value
          cmp_q[ch] <= (wr_fire && wstrb_q && wr_idx == (`IDX_CMP_A + 4'(ch)))
            ? wdata_q : cmp_buf_q[ch];
        end
      end
    end

    timer0_compare_channel u_chan (
      .clock(clock),
      .rst(rst),
      .kind(kind),
      .output_mode(com[ch]),
      .match(match[ch]),
      .cmp_is_top(cmp_is_top[ch]),
      .wrap(wrap),
      .at_top(at_top),
      .count_up(count_up_q),
      .wave_q(wave[ch])
    );

    // Pin level and enable, registered
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        pin_out_q[ch] <= 1'b0;
        pin_oe_q[ch] <= 1'b0;
      end else begin
        // (R1) Waveform overrides the port value
        pin_out_q[ch] <= (com[ch] != `COM_OFF) ? wave[ch] : port[ch];
        // (R2) Driver follows the direction bit
        pin_oe_q[ch] <= dir[ch];
      end
    end

    pin_route_a: assert property (@(posedge clock) disable iff (rst) // R1
      ##1 pin_out_q[ch] == (($past(com[ch]) != `COM_OFF) ? $past(wave[ch]) : $past(port[ch])))
      else $error("pin level not from selected source");
    driver_enable_a: assert property (@(posedge clock) disable iff (rst) // R2
      ##1 pin_oe_q[ch] == $past(dir[ch]))
      else $error("pin driven without direction bit");
  end

  assign pin_a_out = pin_out_q[0];
  assign pin_b_out = pin_out_q[1];
  assign pin_a_oe = pin_oe_q[0];
  assign pin_b_oe = pin_oe_q[1];

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_status_q <= `ST_RESET;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == `ST_OVF && ovf_event) || (i == `ST_MATCH_A && match[0])
            || (i == `ST_MATCH_B && match[1])) begin
          int_status_q[i] <= 1'b1;
        end else if (wr_fire && wstrb_q && wr_idx == `IDX_INT_STATUS && wdata_q[i]) begin
          int_status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_q & int_mask_q);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wrapped_with_ovf;
    counter_q == `CNT_BOTTOM ##0 int_status_q[`ST_OVF];
  endsequence
  sequence turned_with_ovf;
    counter_q == `CNT_STEP ##0 count_up_q ##0 int_status_q[`ST_OVF];
  endsequence

  ctrl_a_reserved_a: assert property ( // R8
    (s_axi_rvalid && rd_idx_q == `IDX_CTRL_A) |-> s_axi_rdata[3:2] == 2'b00)
    else $error("control A reserved bits not zero");
  mode_join_a: assert property ( // R9
    (kind == kind_phase) |-> (wgm_low_q == 2'b01 && top_from_compare == mode_hi_q))
    else $error("phase mode not from joined field");
  normal_max_ovf_a: assert property ( // R10
    (kind == kind_normal && !top_from_compare && run_q && counter_q == `CNT_MAX && !cnt_wr)
      |=> wrapped_with_ovf)
    else $error("normal mode wrap or overflow wrong");
  phase_bottom_ovf_a: assert property ( // R11
    (at_bottom_down && !cnt_wr && top != `CNT_BOTTOM) |=> turned_with_ovf)
    else $error("phase mode bottom overflow wrong");
  phase_top_load_a: assert property ( // R11
    (kind == kind_phase && at_top && count_up_q) |=> cmp_q[1] == $past(cmp_buf_q[1]))
    else $error("phase mode buffer not loaded at top");
  fast_cmp_top_ovf_a: assert property ( // R12
    (kind == kind_fast && ovf_at_top && at_top && !cnt_wr) |=> wrapped_with_ovf)
    else $error("fast mode top overflow wrong");
  fast_bottom_load_a: assert property ( // R12
    (kind == kind_fast && !load_buf) |=> $stable(cmp_q[1]))
    else $error("fast mode buffer loaded off bottom");
endmodule

// File: dv/timer0_waveform_mode_control_bench.sv
// Self-checking bench for the timer0 waveform block
`timescale 1ns/100ps
module timer0_waveform_mode_control_bench;
  logic clock = 0, rst = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int error_cnt = 0, n_compared = 0;
  // 200 MHz clock
  always #2.5 clock = ~clock;
  timer0_waveform_mode_control DUT (
    .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_a_out, .pin_a_oe, .pin_b_out,
    .pin_b_oe, .irq);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // bready stays high, so back-to-back calls drive it once per step
    resp = s_axi_bresp;
  endtask
  // Bus read, data and response kept in rdat and resp
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // Reserved bits, unmapped place, pin routing and drivers
  task automatic t_regs();
    wr(8'h00, 32'hfc);
    rd(8'h00);
    chk(rdat, 32'hf0);
    wr(8'h00, 32'h00);
    rd(8'h20);
    chk(resp, 2'b10);
    wr(8'h20, 32'h0);
    chk(resp, 2'b10);
    wr(8'h1c, 32'h30);
    repeat (2) @(posedge clock);
    chk({pin_a_oe, pin_b_oe, pin_a_out, pin_b_out}, 4'h3);
    wr(8'h1c, 32'h03);
    repeat (2) @(posedge clock);
    chk({pin_a_oe, pin_b_oe, pin_a_out, pin_b_out}, 4'hc);
  endtask
  // Normal mode: one match per run, so set and clear are each seen once and toggle twice
  task automatic t_nonpwm();
    logic [1:0] code [4] = '{2'b01, 2'b11, 2'b10, 2'b01};
    logic exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    wr(8'h0c, 32'h08);
    wr(8'h10, 32'h08);
    foreach (code[i]) begin
      wr(8'h08, 32'h00);
      wr(8'h00, {24'h0, code[i], code[i], 4'h0});
      wr(8'h04, 32'h01);
      repeat (20) @(posedge clock);
      wr(8'h04, 32'h00);
      repeat (2) @(posedge clock);
      chk({pin_a_out, pin_b_out}, {exp[i], exp[i]});
    end
  endtask
  // Compare at top: the pin settles to a constant level
  task automatic t_pwm(input logic [1:0] m, input logic [1:0] c, input logic e);
    wr(8'h00, {24'h0, c, c, 2'h0, m});
    wr(8'h04, 32'h01);
    repeat (520) @(posedge clock);
    repeat (8) begin
      repeat (37) @(posedge clock);
      chk({pin_a_out, pin_b_out}, {e, e});
    end
    wr(8'h04, 32'h00);
  endtask
  // Compare below top: high cycles of pin A over one full period
  task automatic t_duty(input logic [1:0] m, input int per, input int hi);
    int n = 0;
    wr(8'h00, {24'h0, 4'ha, 2'h0, m});
    wr(8'h04, 32'h01);
    repeat (520) @(posedge clock);
    repeat (per) begin
      @(posedge clock);
      n += pin_a_out;
    end
    wr(8'h04, 32'h00);
    chk(n, hi);
  endtask
  // Overflow flag per mode with compare A at 0x10, masked into irq, then cleared
  task automatic t_irq();
    logic [2:0] mode [5] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h5};
    logic exp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    wr(8'h00, 32'h00);
    wr(8'h0c, 32'h10);
    wr(8'h18, 32'h01);
    foreach (mode[i]) begin
      wr(8'h08, 32'h00);
      wr(8'h00, {30'h0, mode[i][1:0]});
      wr(8'h14, 32'h07);
      wr(8'h04, {28'h0, mode[i][2], 3'h1});
      repeat (60) @(posedge clock);
      wr(8'h04, 32'h00);
      rd(8'h14);
      chk({rdat[0], irq}, {exp[i], exp[i]});
    end
    wr(8'h14, 32'h07);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_regs();
    t_nonpwm();
    wr(8'h0c, 32'hff);
    wr(8'h10, 32'hff);
    t_pwm(2'h3, 2'b11, 1'b0);
    t_pwm(2'h3, 2'b10, 1'b1);
    t_pwm(2'h1, 2'b11, 1'b0);
    t_pwm(2'h1, 2'b10, 1'b1);
    wr(8'h0c, 32'h40);
    wr(8'h10, 32'h40);
    t_duty(2'h3, 256, 65);
    t_duty(2'h1, 510, 128);
    t_irq();
    end_of_test();
  end
  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule
